// ### shared/drc_defines.vh
// Overview of operation
// - at count one, pulse timeout and reload the counter from the reload value.
// - the interval counter decrements on each falling edge of the processor clock.
// - a timeout raises a bus request; nothing happens on the bus before grant.
// - on grant, drive refresh strobe low and run a memory read at the refresh address.
// - deassert the strobe at cycle end, then wait for the next timeout.
// - refresh repeats until reprogrammed, reset, or powerdown.
// - interval register holds a 10-bit reload value; upper six bits reserved.
// - a timeout while a request is pending is ignored, never queued.
// - control bit 15 enables the unit; bits 14 to 10 reserved.
// - control bits 9 to 0 read the live counter; writes to them are ignored.
// - the region register supplies address bits 25 to 14 of each refresh.
// - 7-bit shift register covers 128 patterns; upper bits step per pass; 8192 states.
// - refresh outranks DMA and hold; an external owner's acknowledge is withdrawn.
// - both byte selects stay high during every refresh cycle.
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH

// register indices; byte address is four times the index
`define DRC_IDX_REGION   16'hF4A0
`define DRC_IDX_RELOAD   16'hF4A2
`define DRC_IDX_CONTROL  16'hF4A4
`define DRC_IDX_ROW      16'hF4A6

// field layout
`define DRC_REN_BIT      15
`define DRC_CNT_W        10
`define DRC_REGION_W     12
`define DRC_ROW_W        13
`define DRC_LFSR_W       7

// reset values
`define DRC_RELOAD_RST   10'h000
`define DRC_REGION_RST   12'h000
`define DRC_ROW_RST      13'h007F
`define DRC_LFSR_START   7'h7F

`endif

// ### design/drc_interval.v
`timescale 1ns/10ps
`include "drc_defines.vh"

module drc_interval (
   // clock and reset
   input  wire                     pclk,
   input  wire                     presetn,
   // control
   input  wire                     run,
   input  wire                     load,
   input  wire                     tick,
   input  wire [`DRC_CNT_W-1:0]    reload,
   // status
   output reg  [`DRC_CNT_W-1:0]    count_q,
   output reg                      timeout_q
);

   reg [`DRC_CNT_W-1:0] count_d;
   reg                  timeout_d;

   // down counter with reload at one
   always @* begin
      count_d   = count_q;
      timeout_d = 1'b0;
      if (!run || load) begin
         count_d = reload;
      end else if (tick) begin
         if (count_q <= 10'h001) begin
            count_d   = reload;
            timeout_d = 1'b1;
         end else begin
            count_d = count_q - 10'h001;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q   <= `DRC_RELOAD_RST;
         timeout_q <= 1'b0;
      end else begin
         count_q   <= count_d;
         timeout_q <= timeout_d;
      end
   end

endmodule

// ### design/drc_rowgen.v
`timescale 1ns/10ps
`include "drc_defines.vh"

module drc_rowgen (
   // clock and reset
   input  wire                     pclk,
   input  wire                     presetn,
   // control
   input  wire                     step,
   input  wire                     wr,
   input  wire [`DRC_ROW_W-1:0]    wr_row,
   // row address
   output reg  [`DRC_ROW_W-1:0]    row_q
);

   reg [`DRC_ROW_W-1:0] row_d;
   reg [`DRC_LFSR_W-1:0] lfsr_nx;

   // shift register with the all-zero state spliced in: 128 states
   function [`DRC_LFSR_W-1:0] lfsr_next;
      input [`DRC_LFSR_W-1:0] x;
      reg                     fb;
      begin
         fb        = x[6] ^ x[5] ^ (x[5:0] == 6'h00);
         lfsr_next = {x[5:0], fb};
      end
   endfunction

   // upper bits step once per full pass of the low bits
   always @* begin
      row_d   = row_q;
      lfsr_nx = lfsr_next(row_q[`DRC_LFSR_W-1:0]);
      if (wr) begin
         row_d = wr_row;
      end else if (step) begin
         row_d[`DRC_LFSR_W-1:0] = lfsr_nx;
         if (lfsr_nx == `DRC_LFSR_START) begin
            row_d[`DRC_ROW_W-1:`DRC_LFSR_W] = row_q[`DRC_ROW_W-1:`DRC_LFSR_W] + 6'h01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_q <= `DRC_ROW_RST;
      end else begin
         row_q <= row_d;
      end
   end

endmodule

// ### design/drc_top.v
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "drc_defines.vh"

module drc_top (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [17:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // processor clock and power state
   input  wire          core_clock_half,
   input  wire          powerdown,
   // bus arbitration
   output reg           refresh_req,
   input  wire          refresh_ack,
   output reg           hold_ack_block,
   // refresh bus cycle
   input  wire          bus_ready,
   output reg           refresh_n,
   output reg           mem_read_n,
   output reg  [25:1]   addr_out,
   output reg           addr_oe,
   output reg           low_byte_select_n,
   output reg           high_byte_select_n
);

   // control unit states
   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_REQ   = 2'b01;
   localparam [1:0] ST_CYCLE = 2'b10;
   localparam [1:0] ST_END   = 2'b11;

   // byte address of a register index
   function [17:0] byte_addr;
      input [15:0] idx;
      begin
         byte_addr = {idx, 2'b00};
      end
   endfunction

   // states in which the bus request is held
   function is_busy;
      input [1:0] st;
      begin
         is_busy = (st == ST_REQ) || (st == ST_CYCLE);
      end
   endfunction

   // state in which the refresh read owns the bus
   function is_cycle;
      input [1:0] st;
      begin
         is_cycle = (st == ST_CYCLE);
      end
   endfunction

   // control unit
   reg  [1:0]                 state_q;
   reg  [1:0]                 state_d;

   // software registers
   reg                        enable_q;
   reg  [`DRC_CNT_W-1:0]      reload_q;
   reg  [`DRC_REGION_W-1:0]   region_q;
   reg                        reprog_q;

   // processor clock edge and run gate
   reg                        clk_half_q;
   wire                       tick;
   wire                       run;

   // apb decode and read data
   wire                       acc;
   wire                       wr_en;
   wire                       hit_region;
   wire                       hit_reload;
   wire                       hit_control;
   wire                       hit_row;
   wire                       hit_any;
   reg  [31:0]                rdata_d;

   // interval timer and row counter
   wire [`DRC_CNT_W-1:0]      count;
   wire                       timeout;
   wire [`DRC_ROW_W-1:0]      row;
   wire                       row_step;

   // apb decode
   assign acc         = psel & penable & ~pready;
   assign wr_en       = psel & penable & pready & pwrite & ~pslverr;
   assign hit_region  = (paddr == byte_addr(`DRC_IDX_REGION));
   assign hit_reload  = (paddr == byte_addr(`DRC_IDX_RELOAD));
   assign hit_control = (paddr == byte_addr(`DRC_IDX_CONTROL));
   assign hit_row     = (paddr == byte_addr(`DRC_IDX_ROW));
   assign hit_any     = hit_region | hit_reload | hit_control | hit_row;

   // falling edge of the processor clock, seen between two samples;
   // the history flop resets low so a pin idling low gives no false edge
   assign tick = clk_half_q & ~core_clock_half;

   // counting stops when disabled or in powerdown
   assign run = enable_q & ~powerdown;

   // read data mux, reserved bits read zero except bit 0 of the row word, which reads one
   always @* begin
      rdata_d = 32'h00000000;
      if (hit_region) begin
         rdata_d[`DRC_REGION_W-1:0] = region_q;
      end else if (hit_reload) begin
         rdata_d[`DRC_CNT_W-1:0] = reload_q;
      end else if (hit_control) begin
         rdata_d[`DRC_REN_BIT]     = enable_q;
         rdata_d[`DRC_CNT_W-1:0]   = count;
      end else if (hit_row) begin
         rdata_d[`DRC_ROW_W:1] = row;
         rdata_d[0]            = 1'b1;
      end
   end

   // apb handshake: ready one cycle into the access phase, error for unmapped offsets
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~hit_any;
      end
   end

   // read data stands only in the ready cycle so a stale word never leaks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (acc && !pwrite) begin
         prdata <= rdata_d;
      end else begin
         prdata <= 32'h00000000;
      end
   end

   // region field; reserved upper bits are not stored and read zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         region_q <= `DRC_REGION_RST;
      end else if (wr_en && hit_region) begin
         region_q <= pwdata[`DRC_REGION_W-1:0];
      end
   end

   // interval reload value; reserved upper bits are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_q <= `DRC_RELOAD_RST;
      end else if (wr_en && hit_reload) begin
         reload_q <= pwdata[`DRC_CNT_W-1:0];
      end
   end

   // enable bit; the live count bits of this word are read only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= 1'b0;
      end else if (wr_en && hit_control) begin
         enable_q <= pwdata[`DRC_REN_BIT];
      end
   end

   // a write to the reload or control word restarts the interval and drops a
   // request that has not been granted yet
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reprog_q <= 1'b0;
      end else begin
         reprog_q <= wr_en & (hit_reload | hit_control);
      end
   end

   // processor clock history for edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_half_q <= 1'b0;
      end else begin
         clk_half_q <= core_clock_half;
      end
   end

   // interval timer
   drc_interval u_interval (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (run),
      .load      (reprog_q),
      .tick      (tick),
      .reload    (reload_q),
      .count_q   (count),
      .timeout_q (timeout)
   );

   // row counter advances when a refresh cycle completes
   assign row_step = (state_q == ST_END);

   drc_rowgen u_rowgen (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (row_step),
      .wr      (wr_en & hit_row),
      .wr_row  (pwdata[`DRC_ROW_W:1]),
      .row_q   (row)
   );

   // control unit sequencing
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (timeout && run) begin
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            // a stop or reprogram before the grant drops the request
            if (!run || reprog_q) begin
               state_d = ST_IDLE;
            end else if (refresh_ack) begin
               state_d = ST_CYCLE;
            end
         end
         ST_CYCLE: begin
            if (bus_ready) begin
               state_d = ST_END;
            end
         end
         ST_END: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // control unit state; a timeout seen outside idle is simply dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // bus request and hold withdrawal stand from request to the end of the read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_req    <= 1'b0;
         hold_ack_block <= 1'b0;
      end else begin
         refresh_req    <= is_busy(state_d);
         hold_ack_block <= is_busy(state_d);
      end
   end

   // refresh strobe and memory read run only while the bus is granted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_n  <= 1'b1;
         mem_read_n <= 1'b1;
         addr_oe    <= 1'b0;
      end else begin
         refresh_n  <= ~is_cycle(state_d);
         mem_read_n <= ~is_cycle(state_d);
         addr_oe    <= is_cycle(state_d);
      end
   end

   // refresh address driven for the whole read; it keeps its last value after
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_out <= 25'h0000000;
      end else if (is_cycle(state_d)) begin
         addr_out <= {region_q, row};
      end
   end

   // both byte selects stay high for the whole refresh read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_byte_select_n  <= 1'b1;
         high_byte_select_n <= 1'b1;
      end else begin
         low_byte_select_n  <= 1'b1;
         high_byte_select_n <= 1'b1;
      end
   end

endmodule

// ### tb/drc_asserts.sv
`timescale 1ns/10ps
module drc_asserts (
   // clock, reset, apb
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [17:0] paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   // refresh side
   input logic        refresh_req,
   input logic        refresh_ack,
   input logic        hold_ack_block,
   input logic        bus_ready,
   input logic        refresh_n,
   input logic        mem_read_n,
   input logic [25:1] addr_out,
   input logic        addr_oe,
   input logic        low_byte_select_n,
   input logic        high_byte_select_n
);
   logic [11:0] region_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow of the region field, taken when a write commits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) region_q <= 12'h000;
      else if (psel && penable && pready && pwrite && !pslverr && paddr == 18'h3D280)
         region_q <= pwdata[11:0];
   end
   a_byte_sel_high: assert property (!refresh_n |-> low_byte_select_n && high_byte_select_n)
      else $error("byte select low in refresh");
   a_grant_first: assert property ($fell(refresh_n) |-> $past(refresh_req) && $past(refresh_ack))
      else $error("strobe without grant");
   a_strobe_read: assert property (!refresh_n |-> !mem_read_n && addr_oe)
      else $error("strobe without read cycle");
   a_strobe_end: assert property (!refresh_n && bus_ready |=> refresh_n && !refresh_req)
      else $error("strobe not ended");
   a_strobe_hold: assert property (!refresh_n && !bus_ready |=> !refresh_n)
      else $error("strobe ended early");
   a_idle_gap: assert property ($rose(refresh_n) |=> refresh_n)
      else $error("no idle cycle");
   a_hold_block: assert property (hold_ack_block == refresh_req)
      else $error("hold block differs from request");
   a_region_addr: assert property (!refresh_n |-> addr_out[25:14] == region_q)
      else $error("region bits wrong");
   a_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
endmodule
bind drc_top drc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .refresh_req, .refresh_ack, .hold_ack_block, .bus_ready, .refresh_n,
   .mem_read_n, .addr_out, .addr_oe, .low_byte_select_n, .high_byte_select_n);

// ### tb/drc_dram_model.sv
`timescale 1ns/10ps
module drc_dram_model (
   // clock and reset
   input  logic       pclk,
   input  logic       presetn,
   // grant delay in cycles
   input  logic [7:0] ack_delay,
   // refresh link
   input  logic       refresh_req,
   input  logic       refresh_n,
   output logic       refresh_ack,
   output logic       bus_ready,
   output logic       ras_n
);
   logic [7:0] cnt_q;
   // row strobe follows the refresh strobe
   assign ras_n = refresh_n;
   // grant after a delay, end the read one cycle into the strobe
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         refresh_ack <= 1'b0;
         bus_ready <= 1'b0;
      end else begin
         cnt_q <= refresh_req ? cnt_q + 8'h01 : 8'h00;
         refresh_ack <= refresh_req && cnt_q >= ack_delay;
         bus_ready <= !refresh_n && !bus_ready;
      end
   end
endmodule

// ### tb/drc_top_bench.sv
`timescale 1ns/10ps
module drc_top_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, e, cch = 0, pd = 0, req, ack, blk, brdy, rn, mrn, oe, lb, hb, ras;
   logic [25:1] ao, a;
   logic [7:0] dly = 0;
   logic [12:0] row;
   int n_mismatch = 0, checked = 0, cyc = 0, last = 0, gap = 0, n_req = 0, n0;
   logic req_d = 0;
   drc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .core_clock_half(cch), .powerdown(pd), .refresh_req(req),
      .refresh_ack(ack), .hold_ack_block(blk), .bus_ready(brdy), .refresh_n(rn),
      .mem_read_n(mrn), .addr_out(ao), .addr_oe(oe), .low_byte_select_n(lb),
      .high_byte_select_n(hb));
   drc_dram_model far (.pclk, .presetn, .ack_delay(dly), .refresh_req(req),
      .refresh_n(rn), .refresh_ack(ack), .bus_ready(brdy), .ras_n(ras));
   always #20 pclk = ~pclk;
   // processor clock at half rate, request spacing monitor
   always @(posedge pclk) begin
      cch <= ~cch;
      cyc++;
      if (req === 1 && req_d !== 1) begin
         gap = cyc - last;
         last = cyc;
         n_req++;
      end
      req_d = req;
   end
   task print_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(string n, logic [31:0] x, logic [31:0] g);
      checked++;
      if (g !== x) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, x, g);
      end
   endtask
   task apb(logic w, logic [17:0] ad, logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); k++; end while (pready !== 1 && k < 20);
      r = prdata; e = pslverr; psel <= 0; penable <= 0;
      if (k >= 20) begin n_mismatch++; print_verdict; end
   endtask
   task rd(logic [17:0] ad, logic [31:0] x);
      apb(0, ad, 0);
      chk("read", x, r);
   endtask
   task get_addr;
      int k;
      for (k = 0; k < 600 && rn !== 0; k++) @(posedge pclk);
      if (k >= 600) begin n_mismatch++; print_verdict; end
      a = ao;
      chk("ras", 0, ras);
      for (k = 0; k < 600 && rn !== 1; k++) @(posedge pclk);
      if (k >= 600 || a === 'x) begin n_mismatch++; print_verdict; end
   endtask
   function automatic logic [12:0] nxt(logic [12:0] x);
      logic [6:0] l;
      l = {x[5:0], x[6] ^ x[5] ^ (x[5:0] == 6'h00)};
      return {x[12:7] + (l == 7'h7F), l};
   endfunction
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      rd(18'h3D280, 0); rd(18'h3D288, 0); rd(18'h3D290, 0); rd(18'h3D298, 32'hFF);
      apb(0, 18'h3D284, 0); chk("err", 1, e); chk("unmapped", 0, r);
      apb(1, 18'h3D288, 32'hFFFF); rd(18'h3D288, 32'h3FF);
      apb(1, 18'h3D288, 5); apb(1, 18'h3D290, 32'h3FF); rd(18'h3D290, 5);
      apb(1, 18'h3D280, 32'hFABC); rd(18'h3D280, 32'hABC);
      apb(1, 18'h3D298, 32'h3F7F); rd(18'h3D298, 32'h3F7F);
      row = 13'h1FBF;
      apb(1, 18'h3D290, 32'h8000);
      for (int i = 0; i < 130; i++) begin
         get_addr; chk("addr", {12'hABC, row}, a); row = nxt(row);
      end
      chk("gap", 10, gap);
      dly <= 25;
      repeat (2) begin get_addr; row = nxt(row); end
      chk("slow gap", 1, gap % 10 == 0 && gap > 10);
      dly <= 200;
      for (int k = 0; k < 40 && req !== 1; k++) @(posedge pclk);
      chk("pd pend", 1, req);
      pd <= 1;
      repeat (3) @(posedge pclk);
      chk("pd drop", 0, req);
      n0 = n_req;
      repeat (60) @(posedge pclk);
      chk("pd req", n0, n_req);
      pd <= 0; dly <= 0;
      get_addr; chk("resume", {12'hABC, row}, a); row = nxt(row);
      dly <= 200;
      apb(1, 18'h3D290, 0);
      repeat (20) @(posedge pclk);
      rd(18'h3D298, {18'h0, row, 1'b1});
      presetn <= 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      rd(18'h3D290, 0); rd(18'h3D298, 32'hFF);
      print_verdict;
   end
endmodule
